// File: ccpw_map.vh
// Notes on behaviour
// - high-speed output inverts the module pin on each counter/compare equality
// - high-speed output needs invert-on-hit, hit-sets-flag and comparator enable all set
// - all PWM modules share one counter, so all run at one frequency
// - PWM frequency follows the tick source chosen for the shared counter
// - PWM pin low while count low byte below active duty, else high
// - on count low byte wrap FF to 00, reload byte copies into active duty
// - PWM needs both the PWM bit and comparator enable set
// - only module 4 can be the watchdog; otherwise it works as any module
// - armed watchdog raises an internal reset when module 4 compare equals counter with hit-sets-flag set and PWM clear
// - watchdog reset never drives the external reset pin
// - array interrupt needs array enable bit 6 and global enable bit 7 set
// - mode bits: compare enable 6, hit-sets-flag 3, invert 2, PWM 1, irq enable 0
// - with hit-sets-flag set and PWM clear, equality sets the module hit flag
`ifndef CCPW_MAP_VH
`define CCPW_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCPW_OFF_CTRL 8'h00
`define CCPW_OFF_STATUS 8'h04
`define CCPW_OFF_IRQ_EN 8'h08
`define CCPW_OFF_MASK 8'h0C
`define CCPW_OFF_COUNT 8'h10
`define CCPW_OFF_MODE_BASE 8'h20
`define CCPW_OFF_CMP_BASE 8'h40

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCPW_CTRL_RUN 0
`define CCPW_CTRL_WD_ARM 1
`define CCPW_MODE_COMP_EN 6
`define CCPW_MODE_HIT_FLAG 3
`define CCPW_MODE_INVERT 2
`define CCPW_MODE_PWM 1
`define CCPW_MODE_IRQ_EN 0
`define CCPW_IEN_ARRAY 6
`define CCPW_IEN_GLOBAL 7
`define CCPW_ST_OVF 7

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define CCPW_RST_BYTE 8'h00
`define CCPW_RST_WORD 16'h0000
`define CCPW_RST_MODE 7'h00
`define CCPW_MODE_WMASK 7'h4F
`define CCPW_IEN_WMASK 8'hC0
`define CCPW_ST_WMASK 8'h9F
`define CCPW_LOW_WRAP 8'hFF
`define CCPW_CNT_TOP 16'hFFFF

`endif

// File: ccpw_top.v
`timescale 1ns/1ps
`include "ccpw_map.vh"

module ccpw_top #(
    parameter NMOD = 5,
    parameter WD_MOD = 4
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // tick from the selected counter clock source
    input wire count_tick,
    // module outputs
    output reg [NMOD-1:0] module_output_pin,
    // interrupt and internal chip reset
    output reg irq,
    output reg wdt_reset
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    localparam [3:0] SEL_CTRL = 4'h0;
    localparam [3:0] SEL_STATUS = 4'h1;
    localparam [3:0] SEL_IRQ_EN = 4'h2;
    localparam [3:0] SEL_MASK = 4'h3;
    localparam [3:0] SEL_COUNT = 4'h4;
    localparam [3:0] SEL_MODE = 4'h5;
    localparam [3:0] SEL_CMP = 4'h6;
    localparam [3:0] SEL_NONE = 4'hF;

    function [3:0] reg_sel;
        input [7:0] a;
        begin
            reg_sel = SEL_NONE;
            if (a == `CCPW_OFF_CTRL)
                reg_sel = SEL_CTRL;
            else if (a == `CCPW_OFF_STATUS)
                reg_sel = SEL_STATUS;
            else if (a == `CCPW_OFF_IRQ_EN)
                reg_sel = SEL_IRQ_EN;
            else if (a == `CCPW_OFF_MASK)
                reg_sel = SEL_MASK;
            else if (a == `CCPW_OFF_COUNT)
                reg_sel = SEL_COUNT;
            else if (a[1:0] == 2'b00 && a[4:2] < NMOD) begin
                if (a[7:5] == `CCPW_OFF_MODE_BASE >> 5)
                    reg_sel = SEL_MODE;
                else if (a[7:5] == `CCPW_OFF_CMP_BASE >> 5)
                    reg_sel = SEL_CMP;
            end
        end
    endfunction

    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire [3:0] sel = reg_sel(paddr);
    wire [2:0] mod_idx = paddr[4:2];
    wire wr_done = access_done & pwrite;
    wire rd_done = access_done & ~pwrite;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg run_reg;
    reg wd_arm_reg;
    reg [7:0] status_reg;
    reg [7:0] status_next;
    reg [7:0] irq_en_reg;
    reg [7:0] mask_reg;
    reg [15:0] count_reg;
    reg step_reg;
    reg [6:0] mode_reg [0:NMOD-1];
    reg [7:0] active_duty_byte [0:NMOD-1];
    reg [7:0] duty_reload_byte [0:NMOD-1];
    reg [31:0] rdata_next;
    integer i;

    wire step = run_reg & count_tick;
    wire low_wrap = step & (count_reg[7:0] == `CCPW_LOW_WRAP);
    wire cnt_ovf = step & (count_reg == `CCPW_CNT_TOP);

    // ----------------------------------------------------------------
    // per-module compare decode
    // ----------------------------------------------------------------
    wire [NMOD-1:0] hit;
    wire [NMOD-1:0] hso_on;
    wire [NMOD-1:0] pwm_on;
    wire [NMOD-1:0] flag_set;
    wire [NMOD-1:0] pwm_level;
    wire [NMOD-1:0] irq_gate;

    genvar g;
    generate
        for (g = 0; g < NMOD; g = g + 1) begin : gmod
            // match only in the cycle after an increment
            assign hit[g] = step_reg & mode_reg[g][`CCPW_MODE_COMP_EN] &
                (count_reg == {duty_reload_byte[g], active_duty_byte[g]});
            assign hso_on[g] = mode_reg[g][`CCPW_MODE_COMP_EN] &
                mode_reg[g][`CCPW_MODE_HIT_FLAG] & mode_reg[g][`CCPW_MODE_INVERT] &
                ~mode_reg[g][`CCPW_MODE_PWM];
            assign pwm_on[g] = mode_reg[g][`CCPW_MODE_COMP_EN] &
                mode_reg[g][`CCPW_MODE_PWM];
            assign flag_set[g] = hit[g] & mode_reg[g][`CCPW_MODE_HIT_FLAG] &
                ~mode_reg[g][`CCPW_MODE_PWM];
            // shared count low byte gives every module one period
            assign pwm_level[g] = (count_reg[7:0] >= active_duty_byte[g]);
            assign irq_gate[g] = mode_reg[g][`CCPW_MODE_IRQ_EN];
        end
    endgenerate

    // module 4 doubles as the watchdog only while armed
    wire wd_fire = wd_arm_reg & hit[WD_MOD] &
        mode_reg[WD_MOD][`CCPW_MODE_HIT_FLAG] & ~mode_reg[WD_MOD][`CCPW_MODE_PWM];

    // ----------------------------------------------------------------
    // read mux and status update
    // ----------------------------------------------------------------
    always @* begin
        rdata_next = 32'h0000_0000;
        case (sel)
            SEL_CTRL: begin
                rdata_next[`CCPW_CTRL_RUN] = run_reg;
                rdata_next[`CCPW_CTRL_WD_ARM] = wd_arm_reg;
            end
            SEL_STATUS: rdata_next[7:0] = status_reg;
            SEL_IRQ_EN: rdata_next[7:0] = irq_en_reg;
            SEL_MASK: rdata_next[7:0] = mask_reg;
            SEL_COUNT: rdata_next[15:0] = count_reg;
            SEL_MODE: rdata_next[6:0] = mode_reg[mod_idx];
            SEL_CMP: rdata_next[15:0] = {duty_reload_byte[mod_idx], active_duty_byte[mod_idx]};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always @* begin
        status_next = status_reg;
        // clear only what the read returned; new events win
        if (rd_done && sel == SEL_STATUS)
            status_next = status_next & ~prdata[7:0];
        status_next[NMOD-1:0] = status_next[NMOD-1:0] | flag_set;
        status_next[`CCPW_ST_OVF] = status_next[`CCPW_ST_OVF] | cnt_ovf;
        status_next = status_next & `CCPW_ST_WMASK;
    end

    // ----------------------------------------------------------------
    // apb slave: one wait-free access phase, data latched in setup
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            if (setup_ph) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_next;
                pslverr <= (sel == SEL_NONE);
            end else if (access_done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control, counter and status registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
            wd_arm_reg <= 1'b0;
            status_reg <= `CCPW_RST_BYTE;
            irq_en_reg <= `CCPW_RST_BYTE;
            mask_reg <= `CCPW_RST_BYTE;
            count_reg <= `CCPW_RST_WORD;
            step_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_done && sel == SEL_CTRL) begin
                run_reg <= pwdata[`CCPW_CTRL_RUN];
                wd_arm_reg <= pwdata[`CCPW_CTRL_WD_ARM];
            end
            if (wr_done && sel == SEL_IRQ_EN)
                irq_en_reg <= pwdata[7:0] & `CCPW_IEN_WMASK;
            if (wr_done && sel == SEL_MASK)
                mask_reg <= pwdata[7:0] & `CCPW_ST_WMASK;
            // a software write to the counter overrides the increment
            if (wr_done && sel == SEL_COUNT) begin
                count_reg <= pwdata[15:0];
                step_reg <= 1'b0;
            end else begin
                if (step)
                    count_reg <= count_reg + 16'h0001;
                step_reg <= step;
            end
        end
    end

    // ----------------------------------------------------------------
    // module modes, duty bytes and outputs
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < NMOD; i = i + 1) begin
                mode_reg[i] <= `CCPW_RST_MODE;
                active_duty_byte[i] <= `CCPW_RST_BYTE;
                duty_reload_byte[i] <= `CCPW_RST_BYTE;
            end
            module_output_pin <= {NMOD{1'b0}};
        end else begin
            for (i = 0; i < NMOD; i = i + 1) begin
                if (wr_done && sel == SEL_MODE && mod_idx == i)
                    mode_reg[i] <= pwdata[6:0] & `CCPW_MODE_WMASK;
                if (wr_done && sel == SEL_CMP && mod_idx == i) begin
                    active_duty_byte[i] <= pwdata[7:0];
                    duty_reload_byte[i] <= pwdata[15:8];
                end else if (low_wrap && pwm_on[i]) begin
                    active_duty_byte[i] <= duty_reload_byte[i];
                end
                if (pwm_on[i])
                    module_output_pin[i] <= pwm_level[i];
                else if (hso_on[i] && hit[i])
                    module_output_pin[i] <= ~module_output_pin[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt and watchdog reset
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            wdt_reset <= 1'b0;
        end else begin
            irq <= irq_en_reg[`CCPW_IEN_GLOBAL] & irq_en_reg[`CCPW_IEN_ARRAY] &
                (|(status_reg[NMOD-1:0] & mask_reg[NMOD-1:0] & irq_gate) |
                 (status_reg[`CCPW_ST_OVF] & mask_reg[`CCPW_ST_OVF]));
            // internal reset only; no external reset pin is driven
            wdt_reset <= wd_fire;
        end
    end

endmodule // ccpw_top

// File: ccpw_checker.sv
`timescale 1ns/1ps
module ccpw_checker #(
    parameter NMOD = 5,
    parameter WD_MOD = 4
) (
    // apb
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // counter side
    input logic count_tick,
    input logic [NMOD-1:0] module_output_pin,
    input logic irq,
    input logic wdt_reset
);
    logic [5:0] ix;
    logic mapped;
    assign ix = paddr[7:2];
    // misaligned addresses decode as unmapped, whatever the word index
    assign mapped = (paddr[1:0] == 2'b00) &&
        (ix <= 6'h04 || (ix >= 6'h08 && ix <= 6'h0C) || (ix >= 6'h10 && ix <= 6'h14));

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----
    // properties
    // ----
    property p_rdy_setup; psel && !penable |=> pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
    property p_rdy_once; pready |=> !pready; endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
    property p_rdy_acc; pready |-> psel && penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
    property p_err_dec; pready |-> pslverr == !mapped; endproperty
    a_err_dec: assert property (p_err_dec) else $error("error flag wrong");
    property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    property p_wdt_once; wdt_reset |=> !wdt_reset; endproperty
    a_wdt_once: assert property (p_wdt_once) else $error("reset pulse too long");
    property p_wdt_cause; wdt_reset |-> $past(count_tick, 2) || $past(count_tick, 3); endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("reset without tick");
    property p_pin_cause;
        $changed(module_output_pin) |-> $past(count_tick, 2) || $past(count_tick, 3)
            || $past(pready, 2) || $past(pready, 3);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin moved uncaused");
    property p_irq_fall; $fell(irq) |-> $past(pready, 2) || $past(pready, 3); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncaused");

    c_wdt: cover property (wdt_reset);
    c_pin: cover property ($changed(module_output_pin));
    c_irq: cover property ($rose(irq));
endmodule // ccpw_checker

// File: ccpw_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module ccpw_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, count_tick = 0;
    logic [7:0] paddr = 8'h00, md, d2;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, irq, wdt_reset;
    logic [4:0] module_output_pin;
    logic [15:0] c;
    int n_mismatch = 0, cmp_count = 0, n_wdt = 0, m, k, w0, n2;

    ccpw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_tick(count_tick), .module_output_pin(module_output_pin),
        .irq(irq), .wdt_reset(wdt_reset));

    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) if (wdt_reset === 1'b1) n_wdt++;
    initial begin
        #400000;
        n_mismatch++;
        finish_test();
    end

    // ----
    // drivers
    // ----
    task automatic rst();
        @(posedge pclk) presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_mismatch++;
        rdat = prdata; rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic tick();
        @(posedge pclk) count_tick <= 1'b1;
        @(posedge pclk) count_tick <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // counter lands one below compare, then one tick makes the match
    task automatic hit(input int mm, input logic [7:0] mode);
        c = 16'($urandom);
        apb(1'b1, 8'h10, {16'h0, c});
        apb(1'b1, 8'(8'h40 + mm * 4), {16'h0, c + 16'h1});
        apb(1'b1, 8'(8'h20 + mm * 4), {24'h0, mode});
        tick();
    endtask
    // expected pin level of a module in pwm mode
    function automatic logic exp_pwm(input logic [7:0] cl, input logic [7:0] duty);
        return cl >= duty;
    endfunction
    // a match inverts the pin only in high-speed output mode
    function automatic logic exp_hso(input logic [7:0] mode);
        return mode[6] & mode[3] & mode[2] & !mode[1];
    endfunction
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    initial begin
        m = $urandom(99425);
        rst();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK(rdat, 32'h0)
        end
        apb(1'b0, 8'h14, 32'h0);
        `CHK({rerr, rdat}, 33'h100000000)
        apb(1'b1, 8'h24, 32'hFFFFFFFF);
        apb(1'b0, 8'h24, 32'h0);
        `CHK(rdat, 32'h4F)
        for (int j = 0; j < 4; j++) begin
            rst();
            m = $urandom % 5;
            md = 8'(32'h4C48440C >> (j * 8));
            apb(1'b1, 8'h00, 32'h1);
            hit(m, md);
            `CHK(module_output_pin[m], exp_hso(md))
            apb(1'b0, 8'h04, 32'h0);
            `CHK(rdat[m], md[3] & md[6])
            tick();
            `CHK(module_output_pin[m], exp_hso(md))
        end
        rst();
        m = $urandom % 5;
        md = 8'($urandom % 254 + 1);
        n2 = (m + 1 + $urandom % 4) % 5;
        d2 = 8'($urandom % 255 + 1);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h10, 32'h10);
        apb(1'b1, 8'(8'h20 + m * 4), 32'h02);
        repeat (3) @(posedge pclk);
        `CHK(module_output_pin[m], 1'b0)
        apb(1'b1, 8'(8'h40 + m * 4), {24'h0, md});
        apb(1'b1, 8'(8'h40 + n2 * 4), {16'h0, d2, md});
        apb(1'b1, 8'(8'h20 + m * 4), 32'h42);
        apb(1'b1, 8'(8'h20 + n2 * 4), 32'h42);
        apb(1'b1, 8'h10, {24'h0, md - 8'h1});
        repeat (3) @(posedge pclk);
        `CHK(module_output_pin[m], exp_pwm(md - 8'h1, md))
        `CHK(module_output_pin[n2], exp_pwm(md - 8'h1, md))
        tick();
        `CHK(module_output_pin[m], exp_pwm(md, md))
        `CHK(module_output_pin[n2], exp_pwm(md, md))
        apb(1'b1, 8'h10, 32'hFF);
        tick();
        `CHK(module_output_pin[m], exp_pwm(8'h00, 8'h00))
        `CHK(module_output_pin[n2], exp_pwm(8'h00, d2))
        rst();
        apb(1'b1, 8'h00, 32'h3);
        w0 = n_wdt;
        hit(4, 8'h48);
        `CHK(n_wdt, w0 + 1)
        hit(3, 8'h48);
        `CHK(n_wdt, w0 + 1)
        apb(1'b1, 8'h00, 32'h1);
        hit(4, 8'h48);
        `CHK(n_wdt, w0 + 1)
        // armed again; main flow moves the compare value ahead before the match
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h10, 32'h1000);
        apb(1'b1, 8'h50, 32'h1002);
        apb(1'b1, 8'h30, 32'h48);
        tick();
        apb(1'b1, 8'h50, 32'h1003);
        tick();
        `CHK(n_wdt, w0 + 1)
        tick();
        `CHK(n_wdt, w0 + 2)
        rst();
        m = $urandom % 5;
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h0C, 32'h1F);
        hit(m, 8'h49);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, 8'h08, 32'(j << 6));
            repeat (3) @(posedge pclk);
            `CHK(irq, j == 3)
        end
        apb(1'b1, 8'(8'h20 + m * 4), 32'h48);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'(8'h20 + m * 4), 32'h49);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdat[m], 1'b1)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h0C, 32'h80);
        apb(1'b1, 8'h10, 32'hFFFF);
        tick();
        `CHK(irq, 1'b1)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdat[7], 1'b1)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h05, 32'h0);
        `CHK(rerr, 1'b1)
        finish_test();
    end
endmodule // ccpw_top_tb

bind ccpw_top ccpw_checker #(.NMOD(NMOD), .WD_MOD(WD_MOD)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
    .module_output_pin(module_output_pin), .irq(irq), .wdt_reset(wdt_reset));
